// ===== hw/capture_mem.sv
`timescale 1ns/10ps
module capture_mem #(
  parameter int DEPTH = 22,
  parameter int AW    = 5
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic [7:0]         rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ===== hw/output_sequencer.sv
`timescale 1ns/10ps
// Function
// R1: Group addresses must be consecutive, no gaps
// R2: Autonomous mode forces address-derived phase offset
// R3: Phase offset is address times 45 degrees
// R4: Low/open/high/10k/11k/12.1k disable sequencing, tracking
// R5: 16.2k first, 23.7k last, 34.8k middle
// R6: 46.4k to 56.2k enable tracking only
// R7: Sync pin input, auto, output per group
// R8: Power-up in ascending address order
// R9: Power-down in descending address order
// R10: Coordinate sequencing through peer event bus
// R11: Host predecessor/successor mode frees address, phase
// R12: Shared enable: high turns on, low off; code goes off if enable returns high in ST_WAIT_OF, until enable rises again
// R13: Own shutdown fault shuts down and broadcasts
// R14: Peer fault shuts down, optionally restarts
// R15: Alert line low on configured faults; code drives it on every fault input, whatever fault_cfg holds
// R16: Host answers alert with alert response
// R17: Host repeats alert response until released
// R18: Capture active only when misc bit 1 set
// R19: Capture read as 22-byte block, anytime
// R20: Shutdown fault stores capture, retry does not
// R21: Capture store takes 700 to 1400 us
// R22: Command 1 loads stored capture into RAM
// R23: Command 2 saves capture only while disabled
module output_sequencer #(
  parameter int NVM_CYC     = seq_pkg::NVM_WR_CYC,
  parameter int NVM_BLK_CYC = seq_pkg::NVM_BLK_WR_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Strap and address
  input  wire logic [4:0]           strap_code,
  input  wire logic [6:0]           dev_addr,
  // Host sequencing configuration
  input  wire logic                 host_mode,
  input  wire logic [6:0]           host_pred,
  input  wire logic [6:0]           host_succ,
  input  wire logic                 host_first,
  input  wire logic                 host_last,
  input  wire logic [3:0]           host_phase,
  // Enable and fault inputs
  input  wire logic                 enable,
  input  wire logic                 fault,
  input  wire seq_pkg::fault_cfg_s  fault_cfg,
  input  wire logic                 alert_clear,
  // Peer event bus
  input  wire seq_pkg::peer_event_s peer_rx,
  input  wire logic                 peer_busy,
  output seq_pkg::peer_event_s      peer_tx,
  // Capture control
  input  wire logic [7:0]           misc_cfg,
  input  wire logic                 cap_cmd_we,
  input  wire logic [7:0]           cap_cmd,
  input  wire logic                 block_write,
  input  wire logic                 cap_sample,
  input  wire logic [7:0]           cap_data,
  input  wire logic                 cap_rd_start,
  input  wire logic                 cap_rd_next,
  output logic [7:0]                cap_rd_data,
  output logic                      cap_rd_last,
  output logic                      nvm_busy,
  // Status outputs
  output logic                      out_on,
  output logic [3:0]                phase_off,
  output seq_pkg::sync_mode_e       sync_mode,
  output logic                      track_en,
  output logic                      alert_n_oe
);

  typedef enum logic [2:0]
  {
    ST_OFF     = 3'b000,
    ST_WAIT_ON = 3'b001,
    ST_ON      = 3'b010,
    ST_WAIT_OF = 3'b011,
    ST_FAULT   = 3'b100
  } seq_state_e;

  function automatic seq_pkg::strap_cfg_s decode_strap(input logic [4:0] code);
    seq_pkg::strap_cfg_s c;
    logic [2:0]          grp;
    logic [1:0]          pos;
    c   = '0;
    grp = 3'(code / 5'h03);
    pos = 2'(code % 5'h03);
    c.sync_mode = (pos == 2'h0) ? seq_pkg::SYNC_IN : (pos == 2'h1) ? seq_pkg::SYNC_AUTO : seq_pkg::SYNC_OUT; // R7
    case (grp)
      3'h2: begin c.seq_en = 1'b1; c.role = seq_pkg::ROLE_FIRST;  end // R5
      3'h3: begin c.seq_en = 1'b1; c.role = seq_pkg::ROLE_LAST;   end // R5
      3'h4: begin c.seq_en = 1'b1; c.role = seq_pkg::ROLE_MIDDLE; end // R5
      3'h5: c.track_en = 1'b1; // R6
      default: c = c; // R4
    endcase
    if (code > seq_pkg::STRAP_R56K2)
    begin
      c = '0;
    end
    return c;
  endfunction

  seq_pkg::strap_cfg_s cfg;
  assign cfg = decode_strap(strap_code);

  logic auto_mode;
  logic first_dev;
  logic last_dev;
  assign auto_mode = cfg.seq_en && !host_mode;
  assign first_dev = host_mode ? host_first : (cfg.role == seq_pkg::ROLE_FIRST);
  assign last_dev  = host_mode ? host_last  : (cfg.role == seq_pkg::ROLE_LAST);

  logic [6:0] pred_addr;
  logic [6:0] succ_addr;
  assign pred_addr = host_mode ? host_pred : 7'(dev_addr - 7'h01); // R1 R11
  assign succ_addr = host_mode ? host_succ : 7'(dev_addr + 7'h01); // R1 R11

  logic seq_active;
  assign seq_active = auto_mode || host_mode;

  logic pred_on;
  logic succ_off;
  logic peer_fault;
  assign pred_on    = peer_rx.valid && peer_rx.code == seq_pkg::EV_ON_DONE  && peer_rx.addr == pred_addr;
  assign succ_off   = peer_rx.valid && peer_rx.code == seq_pkg::EV_OFF_DONE && peer_rx.addr == succ_addr;
  assign peer_fault = peer_rx.valid && peer_rx.code == seq_pkg::EV_FAULT    && peer_rx.addr != dev_addr;

  // Sequencer state
  seq_state_e           st_q, st_d;
  logic                 en_q, en_d;
  logic                 tx_pend_q, tx_pend_d;
  logic [1:0]           tx_code_q, tx_code_d;
  seq_pkg::peer_event_s tx_q, tx_d;
  logic                 alert_q, alert_d;
  logic                 shut_fault;
  logic                 retry_fault;

  assign shut_fault  = fault && fault_cfg.shut_on_fault && !fault_cfg.retry_on_fault;
  assign retry_fault = fault && fault_cfg.retry_on_fault;

  always_comb
  begin
    st_d      = st_q;
    en_d      = enable;
    tx_pend_d = tx_pend_q;
    tx_code_d = tx_code_q;
    tx_d      = '0;
    alert_d   = alert_q;
    if (fault)
    begin
      alert_d = 1'b1; // R15
    end
    else if (alert_clear)
    begin
      alert_d = 1'b0; // R17
    end
    case (st_q)
      ST_OFF:
        if (enable && !en_q)
        begin
          st_d = (!seq_active || first_dev) ? ST_ON : ST_WAIT_ON; // R12 R8
          if (st_d == ST_ON && seq_active)
          begin
            tx_pend_d = 1'b1;
            tx_code_d = seq_pkg::EV_ON_DONE; // R10
          end
        end
      ST_WAIT_ON:
        if (!enable)
        begin
          st_d = ST_OFF;
        end
        else if (pred_on)
        begin
          st_d      = ST_ON; // R8
          tx_pend_d = 1'b1;
          tx_code_d = seq_pkg::EV_ON_DONE; // R10
        end
      ST_ON:
        if (!enable)
        begin
          st_d = (!seq_active || last_dev) ? ST_OFF : ST_WAIT_OF; // R12 R9
          if (st_d == ST_OFF && seq_active)
          begin
            tx_pend_d = 1'b1;
            tx_code_d = seq_pkg::EV_OFF_DONE; // R10
          end
        end
      ST_WAIT_OF:
        if (succ_off || enable)
        begin
          st_d      = ST_OFF; // R9
          tx_pend_d = succ_off;
          tx_code_d = seq_pkg::EV_OFF_DONE; // R10
        end
      ST_FAULT:
        if (!enable)
        begin
          st_d = ST_OFF;
        end
        else if (fault_cfg.restart_on_peer && !fault)
        begin
          st_d = (!seq_active || first_dev) ? ST_ON : ST_WAIT_ON; // R14
          if (st_d == ST_ON && seq_active)
          begin
            tx_pend_d = 1'b1;
            tx_code_d = seq_pkg::EV_ON_DONE;
          end
        end
      default: st_d = ST_OFF;
    endcase
    if (shut_fault && st_q != ST_FAULT && st_q != ST_OFF)
    begin
      st_d      = ST_FAULT; // R13
      tx_pend_d = 1'b1;
      tx_code_d = seq_pkg::EV_FAULT; // R13
    end
    else if (peer_fault && fault_cfg.shut_on_peer && st_q != ST_OFF && st_q != ST_FAULT)
    begin
      st_d = ST_FAULT; // R14
    end
    if (tx_pend_q && !peer_busy && !tx_pend_d)
    begin
      tx_d = '{valid: 1'b1, code: tx_code_q, addr: dev_addr};
    end
    else if (tx_pend_q && !peer_busy && tx_code_d == tx_code_q)
    begin
      tx_d      = '{valid: 1'b1, code: tx_code_q, addr: dev_addr}; // R10
      tx_pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_q      <= ST_OFF;
      en_q      <= 1'b0;
      tx_pend_q <= 1'b0;
      tx_code_q <= seq_pkg::EV_NONE;
      tx_q      <= '0;
      alert_q   <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      en_q      <= en_d;
      tx_pend_q <= tx_pend_d;
      tx_code_q <= tx_code_d;
      tx_q      <= tx_d;
      alert_q   <= alert_d;
    end
  end

  // Configuration and on-state outputs
  logic [3:0]          phase_d, phase_q;
  seq_pkg::sync_mode_e sync_q;
  logic                track_q;
  logic                on_q;

  always_comb
  begin
    phase_d = host_phase;
    if (auto_mode)
    begin
      phase_d = 4'(dev_addr[2:0] * seq_pkg::PHASE_STEP); // R2 R3
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      phase_q <= 4'h0;
      sync_q  <= seq_pkg::SYNC_IN;
      track_q <= 1'b0;
      on_q    <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      sync_q  <= cfg.sync_mode;
      track_q <= cfg.track_en;
      on_q    <= (st_d == ST_ON || st_d == ST_WAIT_OF); // R9
    end
  end

  // Capture and non-volatile store
  localparam int CNT_W = 24;
  logic             cap_en;
  logic             busy_q, busy_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             stored_q, stored_d;
  logic [4:0]       wptr_q, wptr_d;
  logic [4:0]       rptr_q, rptr_d;
  logic             last_q, last_d;
  logic             fault_q;
  logic [CNT_W-1:0] wr_cycles;
  // Copy engine between live capture RAM and stored image
  logic             cp_act_q, cp_act_d;
  logic             cp_dir_q, cp_dir_d;
  logic [4:0]       cp_ptr_q, cp_ptr_d;
  logic             cp_wr_q;
  logic [4:0]       cp_wa_q;
  logic             smp_we;
  logic             ram_we;
  logic [4:0]       ram_waddr;
  logic [7:0]       ram_wdata;
  logic [4:0]       ram_raddr;
  logic [7:0]       ram_rdata;
  logic [7:0]       nvm_rdata;

  // Live sampling pauses while the copy engine owns the RAM
  assign smp_we    = cap_en && cap_sample && !busy_q && !cp_act_q && !cp_wr_q;
  assign ram_we    = (cp_wr_q && cp_dir_q) || smp_we;
  assign ram_waddr = (cp_wr_q && cp_dir_q) ? cp_wa_q : wptr_q;
  assign ram_wdata = (cp_wr_q && cp_dir_q) ? nvm_rdata : cap_data;
  assign ram_raddr = (cp_act_q && !cp_dir_q) ? cp_ptr_q : rptr_d;

  assign cap_en    = misc_cfg[seq_pkg::MISC_CAPTURE_BIT]; // R18
  assign wr_cycles = block_write ? CNT_W'(NVM_BLK_CYC) : CNT_W'(NVM_CYC); // R21

  always_comb
  begin
    busy_d   = busy_q;
    cnt_d    = cnt_q;
    stored_d = stored_q;
    wptr_d   = wptr_q;
    rptr_d   = rptr_q;
    last_d   = 1'b0;
    if (busy_q)
    begin
      cnt_d = CNT_W'(cnt_q - 1'b1);
      if (cnt_q == '0 || cnt_q == CNT_W'(1))
      begin
        busy_d   = 1'b0; // R21
        stored_d = 1'b1;
      end
    end
    else if (cap_en && fault && !fault_q && fault_cfg.shut_on_fault && !retry_fault)
    begin
      busy_d = 1'b1; // R20
      cnt_d  = wr_cycles;
    end
    else if (cap_en && cap_cmd_we && cap_cmd == seq_pkg::CAP_CMD_SAVE && st_q == ST_OFF)
    begin
      busy_d = 1'b1; // R23
      cnt_d  = wr_cycles;
    end
    if (smp_we)
    begin
      wptr_d = (wptr_q == 5'(seq_pkg::CAPTURE_BYTES - 1)) ? 5'h00 : 5'(wptr_q + 5'h01);
    end
    if (cap_cmd_we && cap_cmd == seq_pkg::CAP_CMD_LOAD && stored_q)
    begin
      rptr_d = 5'h00; // R22
    end
    if (cap_rd_start)
    begin
      rptr_d = 5'h00; // R19
    end
    else if (cap_rd_next && rptr_q != 5'(seq_pkg::CAPTURE_BYTES - 1))
    begin
      rptr_d = 5'(rptr_q + 5'h01); // R19
    end
    last_d = (rptr_d == 5'(seq_pkg::CAPTURE_BYTES - 1));
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      busy_q   <= 1'b0;
      cnt_q    <= '0;
      stored_q <= 1'b0;
      wptr_q   <= 5'h00;
      rptr_q   <= 5'h00;
      last_q   <= 1'b0;
      fault_q  <= 1'b0;
    end
    else
    begin
      busy_q   <= busy_d;
      cnt_q    <= cnt_d;
      stored_q <= stored_d;
      wptr_q   <= wptr_d;
      rptr_q   <= rptr_d;
      last_q   <= last_d;
      fault_q  <= fault;
    end
  end

  // Store copies RAM to the image, load copies it back
  always_comb
  begin
    cp_act_d = cp_act_q;
    cp_dir_d = cp_dir_q;
    cp_ptr_d = cp_ptr_q;
    if (!busy_q && busy_d)
    begin
      cp_act_d = 1'b1; // R20 R23
      cp_dir_d = 1'b0;
      cp_ptr_d = 5'h00;
    end
    else if (cap_cmd_we && cap_cmd == seq_pkg::CAP_CMD_LOAD && stored_q && !busy_q)
    begin
      cp_act_d = 1'b1; // R22
      cp_dir_d = 1'b1;
      cp_ptr_d = 5'h00;
    end
    else if (cp_act_q)
    begin
      cp_act_d = (cp_ptr_q != 5'(seq_pkg::CAPTURE_BYTES - 1));
      cp_ptr_d = 5'(cp_ptr_q + 5'h01);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cp_act_q <= 1'b0;
      cp_dir_q <= 1'b0;
      cp_ptr_q <= 5'h00;
      cp_wr_q  <= 1'b0;
      cp_wa_q  <= 5'h00;
    end
    else
    begin
      cp_act_q <= cp_act_d;
      cp_dir_q <= cp_dir_d;
      cp_ptr_q <= cp_ptr_d;
      cp_wr_q  <= cp_act_q;
      cp_wa_q  <= cp_ptr_q;
    end
  end

  capture_mem #(
    .DEPTH (seq_pkg::CAPTURE_BYTES),
    .AW    (5)
  ) u_mem (
    .clk   (clk),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  capture_mem #(
    .DEPTH (seq_pkg::CAPTURE_BYTES),
    .AW    (5)
  ) u_nvm (
    .clk   (clk),
    .we    (cp_wr_q && !cp_dir_q),
    .waddr (cp_wa_q),
    .wdata (ram_rdata),
    .raddr (cp_ptr_q),
    .rdata (nvm_rdata)
  );

  assign cap_rd_data = ram_rdata;

  assign peer_tx     = tx_q;
  assign out_on      = on_q;
  assign phase_off   = phase_q;
  assign sync_mode   = sync_q;
  assign track_en    = track_q;
  assign alert_n_oe  = alert_q;
  assign nvm_busy    = busy_q;
  assign cap_rd_last = last_q;

endmodule

// ===== inc/seq_pkg.sv
package seq_pkg;

  // Strap codes, one per documented setting, in table order
  localparam logic [4:0] STRAP_LOW      = 5'h00;
  localparam logic [4:0] STRAP_OPEN     = 5'h01;
  localparam logic [4:0] STRAP_HIGH     = 5'h02;
  localparam logic [4:0] STRAP_R10K     = 5'h03;
  localparam logic [4:0] STRAP_R11K     = 5'h04;
  localparam logic [4:0] STRAP_R12K1    = 5'h05;
  localparam logic [4:0] STRAP_R14K7    = 5'h06;
  localparam logic [4:0] STRAP_R16K2    = 5'h07;
  localparam logic [4:0] STRAP_R17K8    = 5'h08;
  localparam logic [4:0] STRAP_R21K5    = 5'h09;
  localparam logic [4:0] STRAP_R23K7    = 5'h0a;
  localparam logic [4:0] STRAP_R26K1    = 5'h0b;
  localparam logic [4:0] STRAP_R31K6    = 5'h0c;
  localparam logic [4:0] STRAP_R34K8    = 5'h0d;
  localparam logic [4:0] STRAP_R38K3    = 5'h0e;
  localparam logic [4:0] STRAP_R46K4    = 5'h0f;
  localparam logic [4:0] STRAP_R51K1    = 5'h10;
  localparam logic [4:0] STRAP_R56K2    = 5'h11;
  localparam logic [2:0] STRAP_GROUPS   = 3'h6;

  // Phase offset step in units of 22.5 degrees: 45 degrees
  localparam logic [3:0] PHASE_STEP     = 4'h2;
  localparam int         PHASE_STEP_DEG = 45;

  // Misc settings bit that enables parametric capture
  localparam int         MISC_CAPTURE_BIT = 1;

  // Capture-store command values
  localparam logic [7:0] CAP_CMD_LOAD   = 8'h01;
  localparam logic [7:0] CAP_CMD_SAVE   = 8'h02;

  // Capture size in bytes
  localparam int         CAPTURE_BYTES  = 22;

  // Non-volatile write times
  localparam int         CLK_MHZ        = 25;
  localparam int         NVM_WR_US      = 700;
  localparam int         NVM_BLK_WR_US  = 1400;
  localparam int         NVM_WR_CYC     = NVM_WR_US * CLK_MHZ;
  localparam int         NVM_BLK_WR_CYC = NVM_BLK_WR_US * CLK_MHZ;

  // Peer event bus message codes
  localparam logic [1:0] EV_NONE        = 2'h0;
  localparam logic [1:0] EV_ON_DONE     = 2'h1;
  localparam logic [1:0] EV_OFF_DONE    = 2'h2;
  localparam logic [1:0] EV_FAULT       = 2'h3;

  typedef enum logic [1:0]
  {
    SYNC_IN   = 2'b00,
    SYNC_AUTO = 2'b01,
    SYNC_OUT  = 2'b10
  } sync_mode_e;

  typedef enum logic [1:0]
  {
    ROLE_NONE   = 2'b00,
    ROLE_FIRST  = 2'b01,
    ROLE_MIDDLE = 2'b10,
    ROLE_LAST   = 2'b11
  } seq_role_e;

  typedef struct packed
  {
    logic       seq_en;
    logic       track_en;
    seq_role_e  role;
    sync_mode_e sync_mode;
  } strap_cfg_s;

  typedef struct packed
  {
    logic       valid;
    logic [1:0] code;
    logic [6:0] addr;
  } peer_event_s;

  typedef struct packed
  {
    logic shut_on_fault;
    logic retry_on_fault;
    logic shut_on_peer;
    logic restart_on_peer;
  } fault_cfg_s;

endpackage

// ===== verification/output_sequencer_tb_top.sv
`timescale 1ns/10ps
module output_sequencer_tb_top;
  logic                 clk = 1'b0, resetn = 1'b0, host_mode = 1'b0, host_first = 1'b0, host_last = 1'b0;
  logic                 enable = 1'b0, fault = 1'b0, alert_clear = 1'b0, peer_busy = 1'b0, send = 1'b0;
  logic                 cap_cmd_we = 1'b0, block_write = 1'b0, cap_sample = 1'b0;
  logic                 cap_rd_start = 1'b0, cap_rd_next = 1'b0;
  logic [4:0]           strap_code = 5'h00;
  logic [6:0]           dev_addr = 7'h25, host_pred = 7'h20, host_succ = 7'h31, addr = 7'h00;
  logic [3:0]           host_phase = 4'h3;
  logic [1:0]           code = 2'h0;
  logic [7:0]           misc_cfg = 8'h02, cap_cmd = 8'h00, cap_data = 8'h00;
  seq_pkg::fault_cfg_s  fault_cfg = '{1'b1, 1'b0, 1'b1, 1'b0};
  seq_pkg::peer_event_s peer_rx, peer_tx;
  seq_pkg::sync_mode_e  sync_mode;
  logic [7:0]           cap_rd_data;
  logic [3:0]           phase_off;
  logic                 cap_rd_last, nvm_busy, out_on, track_en, alert_n_oe;
  int                   fails = 0, checks_done = 0;
  always #20 clk = ~clk;
  output_sequencer #(.NVM_CYC(20), .NVM_BLK_CYC(40)) i_dut (
    .clk, .resetn, .strap_code, .dev_addr, .host_mode, .host_pred, .host_succ, .host_first,
    .host_last, .host_phase, .enable, .fault, .fault_cfg, .alert_clear, .peer_rx, .peer_busy,
    .peer_tx, .misc_cfg, .cap_cmd_we, .cap_cmd, .block_write, .cap_sample, .cap_data,
    .cap_rd_start, .cap_rd_next, .cap_rd_data, .cap_rd_last, .nvm_busy, .out_on, .phase_off,
    .sync_mode, .track_en, .alert_n_oe
  );
  peer_model i_peer (.clk, .send, .code, .addr, .peer_rx);
  task automatic ed();
    @(posedge clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #20;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic msg(input logic [1:0] c, input logic [6:0] a);
    ed();
    send <= 1'b1;
    code <= c;
    addr <= a;
    ed();
    send <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    ed();
    cap_cmd <= c;
    cap_cmd_we <= 1'b1;
    ed();
    cap_cmd_we <= 1'b0;
  endtask
  task automatic fill(input logic [7:0] base);
    ed();
    cap_sample <= 1'b1;
    for (int i = 0; i < 22; i++)
    begin
      cap_data <= base + 8'(i);
      ed();
    end
    cap_sample <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] base);
    ed();
    cap_rd_start <= 1'b1;
    for (int i = 0; i < 22; i++)
    begin
      ed();
      cap_rd_start <= 1'b0;
      cap_rd_next <= 1'b0;
      cyc(1);
      chk(cap_rd_data, base + 8'(i));
      chk(8'(cap_rd_last), 8'(i == 21));
      ed();
      cap_rd_next <= 1'b1;
    end
    ed();
    cap_rd_next <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fails++;
    print_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 18; i++)
    begin
      ed();
      strap_code <= 5'(i);
      cyc(3);
      chk(8'(sync_mode), 8'(i % 3));
      chk(8'(track_en), 8'(i >= 15));
      if (i == 7 || i == 10 || i == 13)
        chk(8'(phase_off), 8'(((dev_addr * seq_pkg::PHASE_STEP_DEG) % 360) * 2 / 45));
      chk(8'(out_on), 8'h00);
    end
    $display("test strap table done");
    ed();
    strap_code <= seq_pkg::STRAP_R16K2;
    cyc(2);
    ed();
    enable <= 1'b1;
    cyc(1);
    chk(8'(out_on), 8'h01);
    cyc(1);
    chk(8'({peer_tx.valid, peer_tx.code}), 8'({1'b1, seq_pkg::EV_ON_DONE}));
    chk(8'(peer_tx.addr), 8'(dev_addr));
    cmd(seq_pkg::CAP_CMD_SAVE);
    cyc(2);
    chk(8'(nvm_busy), 8'h00);
    ed();
    enable <= 1'b0;
    cyc(4);
    chk(8'(out_on), 8'h01);
    msg(seq_pkg::EV_OFF_DONE, dev_addr + 7'h01);
    cyc(3);
    chk(8'(out_on), 8'h00);
    $display("test first device done");
    ed();
    strap_code <= seq_pkg::STRAP_R34K8;
    cyc(2);
    ed();
    enable <= 1'b1;
    cyc(4);
    chk(8'(out_on), 8'h00);
    msg(seq_pkg::EV_ON_DONE, dev_addr - 7'h01);
    cyc(3);
    chk(8'(out_on), 8'h01);
    ed();
    fault <= 1'b1;
    cyc(2);
    chk(8'(out_on), 8'h00);
    chk(8'(alert_n_oe), 8'h01);
    chk(8'(nvm_busy), 8'h01);
    ed();
    alert_clear <= 1'b1;
    ed();
    alert_clear <= 1'b0;
    cyc(1);
    chk(8'(alert_n_oe), 8'h01);
    ed();
    fault <= 1'b0;
    alert_clear <= 1'b1;
    ed();
    alert_clear <= 1'b0;
    cyc(1);
    chk(8'(alert_n_oe), 8'h00);
    cyc(30);
    chk(8'(nvm_busy), 8'h00);
    $display("test own fault done");
    ed();
    enable <= 1'b0;
    strap_code <= seq_pkg::STRAP_R16K2;
    fault_cfg <= '{1'b0, 1'b1, 1'b1, 1'b0};
    cyc(3);
    ed();
    enable <= 1'b1;
    cyc(2);
    chk(8'(out_on), 8'h01);
    msg(seq_pkg::EV_FAULT, dev_addr + 7'h01);
    cyc(3);
    chk(8'(out_on), 8'h00);
    ed();
    fault <= 1'b1;
    cyc(3);
    chk(8'(nvm_busy), 8'h00);
    ed();
    fault <= 1'b0;
    enable <= 1'b0;
    cyc(3);
    $display("test peer and retry fault done");
    fill(8'h40);
    rd(8'h40);
    cmd(seq_pkg::CAP_CMD_SAVE);
    cyc(17);
    chk(8'(nvm_busy), 8'h01);
    cyc(3);
    chk(8'(nvm_busy), 8'h00);
    ed();
    block_write <= 1'b1;
    cmd(seq_pkg::CAP_CMD_SAVE);
    cyc(38);
    chk(8'(nvm_busy), 8'h01);
    cyc(5);
    chk(8'(nvm_busy), 8'h00);
    fill(8'h80);
    cmd(seq_pkg::CAP_CMD_LOAD);
    cyc(45);
    rd(8'h40);
    ed();
    misc_cfg <= 8'h00;
    cmd(seq_pkg::CAP_CMD_SAVE);
    cyc(2);
    chk(8'(nvm_busy), 8'h00);
    $display("test capture done");
    ed();
    host_mode <= 1'b1;
    host_first <= 1'b1;
    dev_addr <= 7'h2a;
    cyc(3);
    chk(8'(phase_off), 8'(host_phase));
    ed();
    enable <= 1'b1;
    cyc(2);
    chk(8'(out_on), 8'h01);
    $display("test host chain done");
    print_verdict();
  end
endmodule

// ===== verification/peer_model.sv
`timescale 1ns/10ps
module peer_model (
  // Clock
  input  wire logic            clk,
  // Message request
  input  wire logic            send,
  input  wire logic [1:0]      code,
  input  wire logic [6:0]      addr,
  // Peer event bus
  output seq_pkg::peer_event_s peer_rx
);
  initial peer_rx = '0;
  // Idle fields toggle so a stale message is never seen
  always @(posedge clk)
    if (send)
      peer_rx <= '{valid: 1'b1, code: code, addr: addr};
    else
      peer_rx <= '{valid: 1'b0, code: ~peer_rx.code, addr: ~peer_rx.addr};
endmodule

// ===== verification/seq_chk.sv
`timescale 1ns/10ps
module seq_chk #(
  parameter int NVM_CYC     = 20,
  parameter int NVM_BLK_CYC = 40
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 resetn,
  // Inputs
  input wire logic [4:0]           strap_code,
  input wire logic [6:0]           dev_addr,
  input wire logic                 host_mode,
  input wire logic                 enable,
  input wire logic                 fault,
  input wire seq_pkg::fault_cfg_s  fault_cfg,
  input wire logic                 alert_clear,
  input wire logic                 peer_busy,
  input wire logic                 cap_cmd_we,
  input wire logic [7:0]           cap_cmd,
  input wire logic [7:0]           misc_cfg,
  // Outputs
  input wire seq_pkg::peer_event_s peer_tx,
  input wire logic                 out_on,
  input wire logic [3:0]           phase_off,
  input wire seq_pkg::sync_mode_e  sync_mode,
  input wire logic                 track_en,
  input wire logic                 alert_n_oe,
  input wire logic                 nvm_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [15:0] busy_q;
  logic [15:0] busy_d;
  always_comb busy_d = nvm_busy ? busy_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk) busy_q <= resetn ? busy_d : 16'h0000;
  sequence s_held;
    $stable(strap_code) [*3];
  endsequence
  property p_sync;
    s_held |-> sync_mode == seq_pkg::sync_mode_e'(2'(strap_code % 5'h03)) || strap_code > 5'h11;
  endproperty
  a_sync: assert property (p_sync) else $error("sync mode wrong");
  property p_track;
    s_held |-> track_en == (strap_code >= 5'h0f && strap_code <= 5'h11);
  endproperty
  a_track: assert property (p_track) else $error("tracking wrong");
  property p_phase;
    (!host_mode && $stable(dev_addr) && strap_code inside {5'h07, 5'h0a, 5'h0d}) [*3]
      |-> phase_off == {dev_addr[2:0], 1'b0};
  endproperty
  a_phase: assert property (p_phase) else $error("phase offset wrong");
  property p_on;
    $rose(out_on) && !peer_busy |=> peer_tx.valid && peer_tx.code == seq_pkg::EV_ON_DONE && peer_tx.addr == dev_addr;
  endproperty
  a_on: assert property (p_on) else $error("no on event");
  property p_off;
    $fell(out_on) && !enable && !fault && !peer_busy |=> peer_tx.valid && peer_tx.code == seq_pkg::EV_OFF_DONE;
  endproperty
  a_off: assert property (p_off) else $error("no off event");
  property p_fault;
    $rose(fault) && fault_cfg.shut_on_fault && out_on && !peer_busy
      |-> ##[1:2] (!out_on && peer_tx.valid && peer_tx.code == seq_pkg::EV_FAULT);
  endproperty
  a_fault: assert property (p_fault) else $error("no fault broadcast");
  property p_alert;
    fault && fault_cfg.shut_on_fault |-> ##[1:2] alert_n_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven");
  property p_alert_hold;
    alert_n_oe && (!alert_clear || fault) |=> alert_n_oe;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped");
  property p_save;
    cap_cmd_we && cap_cmd == seq_pkg::CAP_CMD_SAVE && (out_on || !misc_cfg[1]) && !nvm_busy && !fault |=> !nvm_busy;
  endproperty
  a_save: assert property (p_save) else $error("save not refused");
  property p_nvm;
    $fell(nvm_busy) |-> busy_q == NVM_CYC || busy_q == NVM_BLK_CYC;
  endproperty
  a_nvm: assert property (p_nvm) else $error("store length wrong");
endmodule
bind output_sequencer seq_chk #(.NVM_CYC(NVM_CYC), .NVM_BLK_CYC(NVM_BLK_CYC)) i_chk (
  .clk, .resetn, .strap_code, .dev_addr, .host_mode, .enable, .fault, .fault_cfg, .alert_clear,
  .peer_busy, .cap_cmd_we, .cap_cmd, .misc_cfg, .peer_tx, .out_on, .phase_off, .sync_mode,
  .track_en, .alert_n_oe, .nvm_busy
);
